/* hw/mctim_top.v */
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "mctim_consts.vh"

module mctim_top #(
  parameter [2:0] VARIANT = `MCT_VAR_WIDE,
  parameter       DT_W    = 8
) (
  // Clock and reset
  input  wire        CORE_CLK_I,
  input  wire        RST_I,
  // APB slave
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [7:0]  PADDR_I,
  input  wire [31:0] PWDATA_I,
  output wire [31:0] PRDATA_O,
  output wire        PREADY_O,
  output wire        PSLVERR_O,
  // Channel pins
  input  wire [3:0]  CH_I,
  output wire [3:0]  CH_O,
  output wire [3:0]  CH_OE_O,
  output wire [2:0]  CHN_O,
  // Trigger, brake and debug
  input  wire        ETR_I,
  input  wire        SYNC_I,
  input  wire        BRK_I,
  input  wire        DBG_HALT_I,
  output wire        TRGO_O,
  // Interrupt and DMA
  output wire        IRQ_O,
  output wire [4:0]  DMA_REQ_O
);

  // RULE_01: counter width per variant
  localparam        IS_ADV  = (VARIANT == `MCT_VAR_ADV);
  localparam [31:0] CMASK   = (VARIANT == `MCT_VAR_WIDE) ? 32'hFFFFFFFF : 32'h0000FFFF;
  // RULE_04: channel count per variant
  localparam        NCH     = (VARIANT == `MCT_VAR_TWO) ? 2 :
                              (VARIANT == `MCT_VAR_SINGLE) ? 1 : 4;
  // RULE_12: DMA only in wide and advanced
  localparam        HAS_DMA = (VARIANT == `MCT_VAR_WIDE) || IS_ADV;
  // RULE_13: encoder only in wide and four-channel
  localparam        HAS_ENC = (VARIANT == `MCT_VAR_WIDE) || (VARIANT == `MCT_VAR_FOUR);
  localparam        HAS_UD  = HAS_ENC || IS_ADV;
  localparam [3:0]  CH_VLD  = (NCH == 4) ? 4'hF : (NCH == 2) ? 4'h3 : 4'h1;

  function [31:0] fit;
    input [31:0] v;
    begin
      fit = v & CMASK;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [31:0]         ctrl_q;
  reg [15:0]         psc_q;
  reg [31:0]         reload_q;
  reg [31:0]         cnt_q;
  reg [`MCT_ST_W-1:0] st_q;
  reg [`MCT_ST_W-1:0] mask_q;
  reg [4:0]          dmaen_q;
  reg [15:0]         ccm_q;
  reg [DT_W-1:0]     dead_q;
  reg [31:0]         ccr_q [0:3];
  reg                ud_dn_q;
  reg                enc_dn_q;
  reg [3:0]          chp_q;
  reg                trg_prev_q;
  reg [3:0]          ch_q;
  reg [3:0]          oe_q;
  reg                irq_q;
  reg [4:0]          dma_q;
  reg                trgo_q;
  reg                pready_q;
  reg                pslverr_q;
  reg [31:0]         prdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: one wait state, write lands at the edge that sees pready
  wire       acc     = PSEL_I & PENABLE_I;
  wire       wr_en   = acc & pready_q & PWRITE_I;
  wire [5:0] widx    = PADDR_I[7:2];
  wire       map_ok  = (widx <= `MCT_REG_CCR0 + 6'h3);
  wire       wr_ctrl = wr_en & (widx == `MCT_REG_CTRL);
  wire       wr_cnt  = wr_en & (widx == `MCT_REG_CNT);
  wire       wr_stat = wr_en & (widx == `MCT_REG_STAT);

  reg [31:0] rd_c;
  always @* begin
    rd_c = `MCT_RST_ZERO;
    case (widx)
      `MCT_REG_CTRL:   rd_c = ctrl_q;
      `MCT_REG_PSC:    rd_c = {16'h0000, psc_q};
      `MCT_REG_RELOAD: rd_c = reload_q;
      `MCT_REG_CNT:    rd_c = cnt_q;
      `MCT_REG_STAT:   rd_c = {25'h0000000, st_q};
      `MCT_REG_MASK:   rd_c = {25'h0000000, mask_q};
      `MCT_REG_DMAEN:  rd_c = {27'h0000000, dmaen_q};
      `MCT_REG_CCMODE: rd_c = {16'h0000, ccm_q};
      `MCT_REG_DEAD:   rd_c = {{(32-DT_W){1'b0}}, dead_q};
      default: begin
        if (map_ok)
          rd_c = ccr_q[widx[1:0] - 2'h1];
      end
    endcase
  end

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `MCT_RST_ZERO;
    end else begin
      pready_q  <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~map_ok;
      if (acc & ~pready_q & ~PWRITE_I)
        prdata_q <= rd_c;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count source and slave control
  wire [1:0] slv      = ctrl_q[`MCT_CTRL_SLV_LSB+1:`MCT_CTRL_SLV_LSB];
  wire       enc_on   = HAS_ENC & ctrl_q[`MCT_CTRL_ENC];
  wire       trg_src  = ctrl_q[`MCT_CTRL_TSEL] ? SYNC_I : ETR_I;
  wire       trg_rise = trg_src & ~trg_prev_q;
  wire       enc_edge = CH_I[0] ^ chp_q[0];
  // RULE_10: freeze also covers the advanced output stage
  // RULE_11: counter held while halted in debug
  wire       frozen   = ctrl_q[`MCT_CTRL_FRZ] & DBG_HALT_I;
  // RULE_14: gate or clock from another timer's trigger
  wire       run      = ctrl_q[`MCT_CTRL_EN] & ~frozen &
                        ((slv != `MCT_SLV_GATED) | trg_src);
  wire       src_tick = enc_on ? enc_edge : (slv == `MCT_SLV_EXTCLK) ? trg_rise : 1'b1;
  wire       tick;
  wire [1:0] dmode    = HAS_UD ? ctrl_q[`MCT_CTRL_DIR_LSB+1:`MCT_CTRL_DIR_LSB] : `MCT_DIR_UP;
  wire       ud       = (dmode == `MCT_DIR_UPDOWN) & ~enc_on;
  wire       go_dn    = enc_on ? enc_dn_q : (dmode == `MCT_DIR_DOWN) | (ud & ud_dn_q);
  wire       adv_off  = IS_ADV & (~ctrl_q[`MCT_CTRL_MOE] | BRK_I | frozen);

  mctim_presc #(
    .PW     (16)
  ) u_presc (
    .clk_i  (CORE_CLK_I),
    .rst_i  (RST_I),
    .clr_i  (~ctrl_q[`MCT_CTRL_EN]),
    .tick_i (run & src_tick),
    .div_i  (psc_q),
    .tick_o (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Counter and update event
  reg upd_c;
  always @* begin
    upd_c = 1'b0;
    if (tick)
      upd_c = go_dn ? (cnt_q == 32'h00000000) : (cnt_q >= reload_q);
  end

  // RULE_02: up, down and centre-aligned counting
  // RULE_15: reload at the boundary and flag update
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_q   <= `MCT_RST_ZERO;
      ud_dn_q <= 1'b0;
    end else if (wr_cnt) begin
      cnt_q   <= fit(PWDATA_I);
    end else if (tick) begin
      if (!go_dn) begin
        if (upd_c & ud & (reload_q != 32'h00000000)) begin
          ud_dn_q <= 1'b1;
          cnt_q   <= fit(reload_q - 32'h00000001);
        end else if (upd_c) begin
          cnt_q   <= `MCT_RST_ZERO;
        end else begin
          cnt_q   <= fit(cnt_q + 32'h00000001);
        end
      end else begin
        if (upd_c & ud) begin
          ud_dn_q <= 1'b0;
          cnt_q   <= fit(32'h00000001) & reload_q;
        end else if (upd_c) begin
          cnt_q   <= reload_q;
        end else begin
          cnt_q   <= fit(cnt_q - 32'h00000001);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  reg [3:0] ref_c;
  reg [3:0] pwm_c;
  reg [3:0] cap_c;
  reg [3:0] cmp_c;
  integer   i;
  integer   j;
  always @* begin
    ref_c = 4'h0;
    pwm_c = 4'h0;
    cap_c = 4'h0;
    cmp_c = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      // RULE_08: ccr above reload is 100 %, zero is 0 %
      // RULE_09: PWM from compare against the counter
      case (ccm_q[4*i +: 2])
        `MCT_CC_PWM1: begin
          pwm_c[i] = CH_VLD[i];
          ref_c[i] = (cnt_q < ccr_q[i]) ^ ccm_q[4*i+2];
        end
        `MCT_CC_PWM2: begin
          pwm_c[i] = CH_VLD[i];
          ref_c[i] = (cnt_q >= ccr_q[i]) ^ ccm_q[4*i+2];
        end
        // RULE_07: channel pin as capture input
        `MCT_CC_CAPT: cap_c[i] = CH_VLD[i] & ((CH_I[i] ^ ccm_q[4*i+2]) &
                                             ~(chp_q[i] ^ ccm_q[4*i+2]));
        default: ref_c[i] = 1'b0;
      endcase
      cmp_c[i] = pwm_c[i] & tick & (cnt_q == ccr_q[i]);
    end
  end
  wire [3:0] cc_evt = cap_c | cmp_c;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers, capture and pin state
  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q     <= `MCT_RST_ZERO;
      psc_q      <= 16'h0000;
      reload_q   <= fit(`MCT_RST_RELOAD);
      mask_q     <= {`MCT_ST_W{1'b0}};
      dmaen_q    <= 5'h00;
      ccm_q      <= 16'h0000;
      dead_q     <= {DT_W{1'b0}};
      for (j = 0; j < 4; j = j + 1)
        ccr_q[j] <= `MCT_RST_ZERO;
      chp_q      <= 4'h0;
      trg_prev_q <= 1'b0;
      enc_dn_q   <= 1'b0;
    end else begin
      chp_q      <= CH_I;
      trg_prev_q <= trg_src;
      if (enc_edge)
        enc_dn_q <= ~(CH_I[0] ^ CH_I[1]);
      if (wr_ctrl)
        ctrl_q <= {20'h00000, PWDATA_I[11:0]};
      // RULE_14: trigger starts the counter, set wins over write
      if (slv == `MCT_SLV_START && trg_rise)
        ctrl_q[`MCT_CTRL_EN] <= 1'b1;
      if (wr_en) begin
        case (widx)
          `MCT_REG_PSC:    psc_q    <= PWDATA_I[15:0];
          `MCT_REG_RELOAD: reload_q <= fit(PWDATA_I);
          `MCT_REG_MASK:   mask_q   <= PWDATA_I[`MCT_ST_W-1:0];
          `MCT_REG_DMAEN:  dmaen_q  <= PWDATA_I[4:0];
          `MCT_REG_CCMODE: ccm_q    <= PWDATA_I[15:0];
          `MCT_REG_DEAD:   dead_q   <= PWDATA_I[DT_W-1:0];
          default: begin
            if (map_ok && widx >= `MCT_REG_CCR0)
              ccr_q[widx[1:0] - 2'h1] <= fit(PWDATA_I);
          end
        endcase
      end
      for (j = 0; j < 4; j = j + 1)
        if (cap_c[j])
          ccr_q[j] <= cnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, interrupt, DMA, trigger out
  wire [`MCT_ST_W-1:0] st_set = {IS_ADV & BRK_I, trg_rise, cc_evt, upd_c};
  wire [`MCT_ST_W-1:0] st_d   = (st_q & ~({`MCT_ST_W{wr_stat}} & PWDATA_I[`MCT_ST_W-1:0]))
                                | st_set;

  always @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st_q   <= {`MCT_ST_W{1'b0}};
      irq_q  <= 1'b0;
      dma_q  <= 5'h00;
      trgo_q <= 1'b0;
      ch_q   <= 4'h0;
      oe_q   <= 4'h0;
    end else begin
      // Set wins over a write-one clear in the same cycle
      st_q   <= st_d;
      irq_q  <= |(st_d & mask_q);
      // RULE_12: DMA requests from update and channel events
      dma_q  <= HAS_DMA ? ({cc_evt, upd_c} & dmaen_q) : 5'h00;
      trgo_q <= upd_c;
      // RULE_10: advanced outputs off in halt, brake or MOE clear
      ch_q   <= ref_c & pwm_c & {4{~adv_off}};
      oe_q   <= pwm_c & {4{~adv_off}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage
  // RULE_05: three dead-band pairs on the advanced variant
  genvar g;
  generate
    if (IS_ADV) begin : g_adv
      wire [2:0] db_p;
      wire [2:0] db_n;
      for (g = 0; g < 3; g = g + 1) begin : g_db
        mctim_deadband #(
          .DW    (DT_W)
        ) u_db (
          .clk_i (CORE_CLK_I),
          .rst_i (RST_I),
          .ref_i (ref_c[g] & pwm_c[g]),
          .dt_i  (dead_q),
          .off_i (adv_off | ~pwm_c[g]),
          .pos_o (db_p[g]),
          .neg_o (db_n[g])
        );
      end
      assign CH_O  = {ch_q[3], db_p};
      assign CHN_O = db_n;
    end else begin : g_gen
      assign CH_O  = ch_q;
      assign CHN_O = 3'h0;
    end
  endgenerate

  assign CH_OE_O   = oe_q;
  assign TRGO_O    = trgo_q;
  assign IRQ_O     = irq_q;
  assign DMA_REQ_O = dma_q;
  assign PRDATA_O  = prdata_q;
  assign PREADY_O  = pready_q;
  assign PSLVERR_O = pslverr_q;

endmodule // mctim_top

/* inc/mctim_consts.vh */
// How it works
// RULE_01: The counter is 32 bits wide in the wide variant and 16 bits in all other variants.
// RULE_02: Wide, four-channel and advanced variants count up, down or up/down; reduced ones up only.
// RULE_03: A prescaler divides the count clock by any integer from 1 to 65536.
// RULE_04: Wide, four-channel and advanced variants have four channels, reduced ones two or one.
// RULE_05: The advanced variant drives three complementary pairs with dead band plus one plain output.
// RULE_06: The advanced variant has a brake input that forces its PWM outputs inactive, and a trigger input.
// RULE_07: The wide variant has a trigger input and four channel pins usable as capture or compare.
// RULE_08: Advanced PWM reaches every duty cycle from 0 % to 100 % inclusive.
// RULE_09: Every variant generates PWM on its channels by comparing against the running counter.
// RULE_10: In debug halt, when enabled, the advanced variant stops counting and disables its PWM outputs.
// RULE_11: In debug halt, when enabled, the general variants hold the counter value.
// RULE_12: Wide and advanced variants issue DMA requests; reduced variants issue none.
// RULE_13: Wide and four-channel variants count quadrature encoder signals on their channel inputs.
// RULE_14: Each timer outputs a trigger event that others use to start, gate or clock their counters.
// RULE_15: At the reload boundary the counter reloads and sets an update flag for interrupt or DMA.
// RULE_16: The dead band is a programmable number of clock cycles on every main output transition.
`ifndef MCTIM_CONSTS_VH
`define MCTIM_CONSTS_VH

// Variants
`define MCT_VAR_WIDE     3'h0
`define MCT_VAR_FOUR     3'h1
`define MCT_VAR_TWO      3'h2
`define MCT_VAR_SINGLE   3'h3
`define MCT_VAR_ADV      3'h4

// Register word indices; the byte address is four times the index
`define MCT_REG_CTRL     6'h00
`define MCT_REG_PSC      6'h01
`define MCT_REG_RELOAD   6'h02
`define MCT_REG_CNT      6'h03
`define MCT_REG_STAT     6'h04
`define MCT_REG_MASK     6'h05
`define MCT_REG_DMAEN    6'h06
`define MCT_REG_CCMODE   6'h07
`define MCT_REG_DEAD     6'h08
`define MCT_REG_CCR0     6'h09

// Control fields
`define MCT_CTRL_EN      0
`define MCT_CTRL_DIR_LSB 1
`define MCT_CTRL_FRZ     3
`define MCT_CTRL_ENC     4
`define MCT_CTRL_SLV_LSB 8
`define MCT_CTRL_TSEL    10
`define MCT_CTRL_MOE     11

// Count directions, slave modes, channel modes
`define MCT_DIR_UP       2'h0
`define MCT_DIR_DOWN     2'h1
`define MCT_DIR_UPDOWN   2'h2
`define MCT_SLV_OFF      2'h0
`define MCT_SLV_GATED    2'h1
`define MCT_SLV_START    2'h2
`define MCT_SLV_EXTCLK   2'h3
`define MCT_CC_OFF       2'h0
`define MCT_CC_PWM1      2'h1
`define MCT_CC_PWM2      2'h2
`define MCT_CC_CAPT      2'h3

// Status bits: update, four channels, trigger, brake
`define MCT_ST_W         7
`define MCT_ST_UPD       0
`define MCT_ST_TRG       5
`define MCT_ST_BRK       6

// Reset values
`define MCT_RST_RELOAD   32'hFFFFFFFF
`define MCT_RST_ZERO     32'h00000000

`endif

/* hw/mctim_presc.v */
`timescale 1ns/1ps
`include "mctim_consts.vh"

module mctim_presc #(
  parameter PW = 16
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // Control
  input  wire          clr_i,
  input  wire          tick_i,
  input  wire [PW-1:0] div_i,
  // Divided tick
  output reg           tick_o
);

  reg [PW-1:0] cnt_q;

  // RULE_03: divide by div+1
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q  <= {PW{1'b0}};
      tick_o <= 1'b0;
    end else if (clr_i) begin
      cnt_q  <= {PW{1'b0}};
      tick_o <= 1'b0;
    end else if (tick_i) begin
      if (cnt_q >= div_i) begin
        cnt_q  <= {PW{1'b0}};
        tick_o <= 1'b1;
      end else begin
        cnt_q  <= cnt_q + {{(PW-1){1'b0}}, 1'b1};
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end

endmodule // mctim_presc

/* hw/mctim_deadband.v */
`timescale 1ns/1ps
`include "mctim_consts.vh"

module mctim_deadband #(
  parameter DW = 8
) (
  // Clock and reset
  input  wire          clk_i,
  input  wire          rst_i,
  // Reference and control
  input  wire          ref_i,
  input  wire [DW-1:0] dt_i,
  input  wire          off_i,
  // Complementary pair
  output reg           pos_o,
  output reg           neg_o
);

  reg          ref_q;
  reg [DW-1:0] cnt_q;

  // RULE_16: both sides low for dt+1 cycles on each edge
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_q <= 1'b0;
      cnt_q <= {DW{1'b0}};
      pos_o <= 1'b0;
      neg_o <= 1'b0;
    end else if (ref_i != ref_q) begin
      ref_q <= ref_i;
      cnt_q <= dt_i;
      pos_o <= 1'b0;
      neg_o <= 1'b0;
    end else if (cnt_q != {DW{1'b0}}) begin
      cnt_q <= cnt_q - {{(DW-1){1'b0}}, 1'b1};
    end else begin
      // RULE_06: brake forces the pair inactive
      pos_o <= ref_q & ~off_i;
      neg_o <= ~ref_q & ~off_i;
    end
  end

endmodule // mctim_deadband

/* dv/mctim_src_model.sv */
`timescale 1ns/1ps
module mctim_src_model (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Request from the bench
  input  wire        go_i,
  // Pins towards the timer
  output logic       etr_o,
  output logic [3:0] ch_o
);
  logic [2:0] sh_q;
  // Pulse is stretched so a synchroniser cannot miss it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh_q  <= 3'h0;
      etr_o <= 1'b0;
      ch_o  <= 4'h1;
    end else begin
      sh_q  <= {sh_q[1:0], go_i};
      etr_o <= go_i | (|sh_q);
      ch_o  <= {ch_o[2:0], ch_o[3] ^ ch_o[2]};
    end
  end
endmodule // mctim_src_model

/* dv/mctim_checker.sv */
`timescale 1ns/1ps
module mctim_checker #(
  parameter [2:0] VARIANT = 3'h0
) (
  input wire        CORE_CLK_I,
  input wire        RST_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [7:0]  PADDR_I,
  input wire [31:0] PWDATA_I,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  input wire [3:0]  CH_O,
  input wire [2:0]  CHN_O,
  input wire        BRK_I,
  input wire        DBG_HALT_I,
  input wire        TRGO_O,
  input wire        IRQ_O,
  input wire [4:0]  DMA_REQ_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  logic [11:0] ctrl_q;
  logic [6:0]  mask_q;
  wire         wr_c = PSEL_I & PENABLE_I & PWRITE_I & PREADY_O & ~PSLVERR_O;
  wire         adv_c = (VARIANT == 3'h4);
  wire         off_c = (CH_O[2:0] == 3'h0) && (CHN_O == 3'h0);
  // Shadow of the writes, so output gating can be judged from the bus
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ctrl_q <= 12'h000;
      mask_q <= 7'h00;
    end else if (wr_c) begin
      if (PADDR_I[7:2] == 6'h00) ctrl_q <= PWDATA_I[11:0];
      if (PADDR_I[7:2] == 6'h05) mask_q <= PWDATA_I[6:0];
    end
  end
  rdy_wait_a: assert property (PSEL_I && $rose(PENABLE_I) |-> !PREADY_O ##1 PREADY_O)
    else $error("ready not in second access cycle");
  rdy_only_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I && $past(PENABLE_I))
    else $error("ready outside access phase");
  err_map_a: assert property (PREADY_O |-> PSLVERR_O == (PADDR_I[7:2] > 6'h0C))
    else $error("error response wrong");
  pair_gap_a: assert property ((CH_O[2:0] & CHN_O) == 3'h0)
    else $error("pair outputs both high");
  dead_pos_a: assert property ($rose(CH_O[0]) |-> !$past(CHN_O[0]))
    else $error("no gap before main output");
  dead_neg_a: assert property ($rose(CHN_O[0]) |-> !$past(CH_O[0]))
    else $error("no gap before complement");
  brk_off_a: assert property (adv_c && BRK_I [*3] |-> off_c)
    else $error("brake left outputs on");
  halt_off_a: assert property (adv_c && (ctrl_q[3] && DBG_HALT_I) [*3] |-> off_c)
    else $error("debug halt left outputs on");
  moe_off_a: assert property (adv_c && !ctrl_q[11] [*3] |-> off_c)
    else $error("outputs on without enable");
  irq_upd_a: assert property (TRGO_O && mask_q[0] |-> ##[0:2] IRQ_O)
    else $error("update did not interrupt");
  irq_mask_a: assert property ($past(mask_q) == 7'h00 |-> !IRQ_O)
    else $error("interrupt while masked");
  dma_upd_a: assert property (DMA_REQ_O[0] |-> TRGO_O)
    else $error("update request without update");
  dma_none_a: assert property (DMA_REQ_O != 5'h00 |-> (VARIANT == 3'h0) || adv_c)
    else $error("reduced variant raised request");
endmodule // mctim_checker

bind mctim_top mctim_checker #(.VARIANT(VARIANT)) u_mctim_checker (.CORE_CLK_I, .RST_I,
  .PSEL_I, .PENABLE_I, .PWRITE_I, .PADDR_I, .PWDATA_I, .PREADY_O, .PSLVERR_O, .CH_O, .CHN_O,
  .BRK_I, .DBG_HALT_I, .TRGO_O, .IRQ_O, .DMA_REQ_O);

/* dv/mctim_tb_top.sv */
`timescale 1ns/1ps
module mctim_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, brk = 1'b0, halt = 1'b0;
  logic        sync = 1'b0, go = 1'b0, rerr, prdy, perr, etr, trgo, irq;
  logic [7:0]  pa = 8'h00;
  logic [31:0] pwd = 32'h0, rdat, prd;
  logic [3:0]  chi, cho, choe;
  logic [2:0]  chn;
  logic [4:0]  dma;
  int          n_fail = 0, checks = 0, n, k, d, p, r;
  localparam logic [7:0] CTRL = 8'h00, PSC = 8'h04, RLD = 8'h08, CNT = 8'h0C, STAT = 8'h10;
  localparam logic [7:0] MASK = 8'h14, DMAEN = 8'h18, CCM = 8'h1C, DEAD = 8'h20;
  localparam logic [7:0] CCR0 = 8'h24, CCR3 = 8'h30, BAD = 8'h40;
  ////////////////////////////////////////////////////////////////////////
  mctim_top #(.VARIANT(3'h4)) u_mctim_top (.CORE_CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd),
    .PREADY_O(prdy), .PSLVERR_O(perr), .CH_I(chi), .CH_O(cho), .CH_OE_O(choe), .CHN_O(chn),
    .ETR_I(etr), .SYNC_I(sync), .BRK_I(brk), .DBG_HALT_I(halt), .TRGO_O(trgo), .IRQ_O(irq),
    .DMA_REQ_O(dma));
  mctim_src_model u_mctim_src_model (.clk_i(clk), .rst_i(rst), .go_i(go), .etr_o(etr),
    .ch_o(chi));
  initial forever #10 clk = ~clk;
  always @(posedge clk) sync <= 1'($urandom % 2);
  // Whole run is well under this span
  initial begin
    #1900000;
    n_fail++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Entered just after a clock edge; leaves one idle edge behind
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] dt);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= dt;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rdat = prd;
    rerr = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    rw(1'b1, a, dt);
  endtask
  task automatic rd(input logic [7:0] a);
    rw(1'b0, a, 32'h0);
  endtask
  task automatic trg(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (trgo !== 1'b1);
  endtask
  function automatic int per(int dr, int ps, int rl);
    return (dr == 2 ? rl : rl + 1) * (ps + 1);
  endfunction
  ////////////////////////////////////////////////////////////////////////
  initial begin
    r = $urandom(33);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(RLD);
    chk("reload", 32'h0000FFFF, rdat);
    wr(BAD, 32'h1);
    chk("slverr", 32'h1, rerr);
    $display("test regs done");
    for (d = 0; d < 3; d++) begin
      p = $urandom % 4;
      r = 4 + $urandom % 8;
      wr(CTRL, 32'h0);
      wr(PSC, p);
      wr(RLD, r);
      wr(CNT, 32'h0);
      wr(CTRL, 32'h1 | (d << 1));
      trg(n);
      trg(n);
      chk("period", per(d, p, r), n);
    end
    wr(DMAEN, 32'h1);
    wr(MASK, 32'h1);
    trg(n);
    chk("dma update", 32'h1, dma[0]);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, irq);
    rd(STAT);
    chk("update flag", 32'h1, rdat[0]);
    wr(MASK, 32'h0);
    wr(STAT, 32'h7F);
    chk("irq masked", 32'h0, irq);
    $display("test periods done");
    wr(CTRL, 32'h9);
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    rd(CNT);
    k = rdat;
    rd(CNT);
    chk("frozen", k, rdat);
    halt <= 1'b0;
    $display("test freeze done");
    wr(CTRL, 32'h0);
    wr(PSC, 32'h0);
    wr(RLD, 32'hF);
    wr(CCM, 32'h1001);
    wr(CCR0, 32'h8);
    wr(CTRL, 32'h801);
    for (p = 0; p < 3; p++) begin
      k = (p == 0) ? 0 : (p == 1) ? 1 + $urandom % 15 : 16;
      wr(CCR3, k);
      repeat (40) @(posedge clk);
      n = 0;
      repeat (16) begin
        @(posedge clk);
        if (cho[3] === 1'b1) n++;
      end
      chk("duty", k, n);
    end
    chk("pwm enable", 32'h9, choe);
    d = $urandom % 4;
    wr(DEAD, d);
    repeat (40) @(posedge clk);
    while (cho[0] !== 1'b1) @(posedge clk);
    while (cho[0] !== 1'b0) @(posedge clk);
    n = 0;
    while (chn[0] !== 1'b1) begin
      @(posedge clk);
      n++;
    end
    chk("dead gap", d + 1, n);
    wr(CTRL, 32'h809);
    halt <= 1'b1;
    repeat (4) @(posedge clk);
    chk("halt off", 32'h0, {cho, chn, choe});
    halt <= 1'b0;
    brk <= 1'b1;
    repeat (4) @(posedge clk);
    chk("brake off", 32'h0, {cho[2:0], chn});
    chk("brake oe", 32'h0, choe);
    rd(STAT);
    chk("brake flag", 32'h1, rdat[6]);
    brk <= 1'b0;
    $display("test pwm done");
    wr(CTRL, 32'h200);
    wr(STAT, 32'h7F);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (6) @(posedge clk);
    rd(CTRL);
    chk("started", 32'h1, rdat[0]);
    rd(STAT);
    chk("trigger flag", 32'h1, rdat[5]);
    $display("test trigger done");
    stop_test();
  end
endmodule // mctim_tb_top
